// ### core/lldoc_defs.svh
/*
 * constants of the extra-lane, sync-word, gain and over-range register group:
 * register indices, byte addresses, field positions and reset values.
 * assumes a 12-bit apb byte address with one 32-bit word per register.
 */
`ifndef LLDOC_DEFS_SVH
`define LLDOC_DEFS_SVH

////////////////////////////////////////////////////////////////////////////////
// register indices, byte address is four times the index
`define LLDOC_IDX_EXTRA_B 12'h20b
`define LLDOC_IDX_SYNC 12'h20f
`define LLDOC_IDX_GAIN 12'h210
`define LLDOC_IDX_THR_I 12'h211
`define LLDOC_IDX_THR_Q 12'h212
`define LLDOC_IDX_CTRL 12'h220
`define LLDOC_IDX_STAT 12'h221
`define LLDOC_IDX_MASK 12'h222
`define LLDOC_WORD 12'h004
`define LLDOC_ADDR_EXTRA_B (`LLDOC_IDX_EXTRA_B * `LLDOC_WORD)
`define LLDOC_ADDR_SYNC (`LLDOC_IDX_SYNC * `LLDOC_WORD)
`define LLDOC_ADDR_GAIN (`LLDOC_IDX_GAIN * `LLDOC_WORD)
`define LLDOC_ADDR_THR_I (`LLDOC_IDX_THR_I * `LLDOC_WORD)
`define LLDOC_ADDR_THR_Q (`LLDOC_IDX_THR_Q * `LLDOC_WORD)
`define LLDOC_ADDR_CTRL (`LLDOC_IDX_CTRL * `LLDOC_WORD)
`define LLDOC_ADDR_STAT (`LLDOC_IDX_STAT * `LLDOC_WORD)
`define LLDOC_ADDR_MASK (`LLDOC_IDX_MASK * `LLDOC_WORD)

////////////////////////////////////////////////////////////////////////////////
// field positions
`define LLDOC_F_EXTRA_SER 0
`define LLDOC_F_GAIN 0
`define LLDOC_F_LINK_EN 0
`define LLDOC_F_PD 1
`define LLDOC_F_TEST_LO 4
`define LLDOC_F_TEST_HI 7
`define LLDOC_S_OVR_I 0
`define LLDOC_S_OVR_Q 1
`define LLDOC_S_LOCKED_WR 2

////////////////////////////////////////////////////////////////////////////////
// reset values and pattern codes
`define LLDOC_RST_EXTRA_B 8'h00
`define LLDOC_RST_SYNC 2'h0
`define LLDOC_RST_GAIN 1'h0
`define LLDOC_RST_THR_I 8'hf2
`define LLDOC_RST_THR_Q 8'hab
`define LLDOC_RST_CTRL 8'h00
`define LLDOC_RST_MASK 3'h0
`define LLDOC_TEST_OFF 4'h0
`define LLDOC_TEST_ALT 4'h5

`endif

// ### core/lldoc_pkg.sv
/*
 * types shared by the register group and whoever connects to it.
 * assumes nothing of its surroundings.
 */
package lldoc_pkg;
	// sync-word content codes, the other two codes are reserved
	typedef enum logic [1:0] {
		LLDOC_SYNC_CRC = 2'h0,
		LLDOC_SYNC_FEC = 2'h2
	} lldoc_sync_t;

	// one signed down-converter output sample
	typedef logic signed [15:0] lldoc_sample_t;
endpackage

// ### core/lldoc_regs.sv
/*
 * extra-lane enables for the second link, sync-word content choice,
 * down-converter gain and over-range flagging of i and q samples,
 * all reached over an apb slave.
 * assumes the link-mode decoder, the samples and the apb master all run on clk,
 * so none of their inputs needs a synchroniser.
 */
// The implementer's own choice: the APB register port.
`include "lldoc_defs.svh"

// Functional notes
// - bits 7:1 switch on link clocks of second-link lanes 1 to 7.
// - bit 0 low gives clocks only; high also powers the extra serializers.
// - extra lanes follow current link mode and test pattern for rate and mode.
// - extra-only lanes send octet ramp when test pattern is 0 or 5.
// - channel power-down wins over extra-lane enables.
// - serializer n is clocked only when lanes 0 to n-1 are enabled.
// - two-bit sync select picks sync-word content, only in 64b/66b modes.
// - select 0 sends crc-12, select 2 sends fec, 1 and 3 reserved.
// - every command field of the sync word is sent as zero.
// - gain bit low gives 0 dB, high doubles the filter output.
// - i threshold, reset 0xf2, sets i-sample control bit 0.
// - detection level is threshold over full scale of 256; the code compares the top byte, giving threshold over 128.
// - q threshold, reset 0xab, sets q-sample control bit 1.
module lldoc_regs #(
	parameter int LANES = 8,
	parameter int AW = 12
)(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// state of the link-mode decoder
	input wire logic [LANES-1:0] mode_lane_enable,
	input wire logic mode_is_64b66b,
	// lane controls of the second link
	output logic [LANES-1:0] lane_clock_enable,
	output logic [LANES-1:0] serializer_power,
	output logic [LANES-1:0] serializer_clock,
	output logic [LANES-1:0] lane_ramp_select,
	output logic [3:0] lane_test_pattern,
	output logic link_enable,
	// sync-word content
	output logic sync_send_crc,
	output logic sync_send_fec,
	output logic [31:0] sync_command_fields,
	// down-converter samples in
	input wire logic sample_valid,
	input wire lldoc_pkg::lldoc_sample_t sample_i,
	input wire lldoc_pkg::lldoc_sample_t sample_q,
	// samples out with control bits
	output logic out_valid,
	output lldoc_pkg::lldoc_sample_t out_i,
	output lldoc_pkg::lldoc_sample_t out_q,
	output logic [1:0] out_control,
	// interrupt
	output logic irq
);

	////////////////////////////////////////////////////////////////////////
	// registers written by software, irq_status set by events; link_ctrl holds link enable, channel
	// power-down and the test pattern, standing in for link registers kept
	// elsewhere
	logic [7:0] extra_lane_enable_link_b;
	logic [1:0] sync_word_content_select;
	logic filter_gain_double;
	logic [7:0] threshold_i_level;
	logic [7:0] threshold_q_level;
	logic [7:0] link_ctrl;
	logic [2:0] irq_status;
	logic [2:0] irq_mask;

	// apb decode; counted from the setup edge, edge 1 opens the access phase,
	// edge 2 raises pready and edge 3 completes the transfer, the only edge where
	// a write lands; the answer never needs more than this one wait state
	wire logic [AW-1:0] addr = paddr;
	wire logic access = psel & penable & ~pready;
	wire logic done = psel & penable & pready;
	wire logic hit_extra = addr == AW'(`LLDOC_ADDR_EXTRA_B);
	wire logic hit_sync = addr == AW'(`LLDOC_ADDR_SYNC);
	wire logic hit_gain = addr == AW'(`LLDOC_ADDR_GAIN);
	wire logic hit_thr_i = addr == AW'(`LLDOC_ADDR_THR_I);
	wire logic hit_thr_q = addr == AW'(`LLDOC_ADDR_THR_Q);
	wire logic hit_ctrl = addr == AW'(`LLDOC_ADDR_CTRL);
	wire logic hit_stat = addr == AW'(`LLDOC_ADDR_STAT);
	wire logic hit_mask = addr == AW'(`LLDOC_ADDR_MASK);
	wire logic mapped = hit_extra | hit_sync | hit_gain | hit_thr_i | hit_thr_q
		| hit_ctrl | hit_stat | hit_mask;
	wire logic wr = done & pwrite & mapped;
	wire logic rd_stat = done & ~pwrite & hit_stat;
	wire logic [7:0] wbyte = pwdata[7:0];

	// read value of each register, reserved bits read as zero so that software
	// may write back what it read without setting anything it did not mean to
	wire logic [31:0] val_extra = {24'h000000, extra_lane_enable_link_b};
	wire logic [31:0] val_sync = {30'h0, sync_word_content_select};
	wire logic [31:0] val_gain = {31'h0, filter_gain_double};
	wire logic [31:0] val_thr_i = {24'h000000, threshold_i_level};
	wire logic [31:0] val_thr_q = {24'h000000, threshold_q_level};
	wire logic [31:0] val_ctrl = {24'h000000, link_ctrl};
	wire logic [31:0] val_stat = {29'h0, irq_status};
	wire logic [31:0] val_mask = {29'h0, irq_mask};

	// read mux; prdata latches it in the wait state, so a read returns
	// the value of the edge before the transfer completes
	logic [31:0] rdata;
	always_comb
	begin
		if (hit_extra)
			rdata = val_extra;
		else if (hit_sync)
			rdata = val_sync;
		else if (hit_gain)
			rdata = val_gain;
		else if (hit_thr_i)
			rdata = val_thr_i;
		else if (hit_thr_q)
			rdata = val_thr_q;
		else if (hit_ctrl)
			rdata = val_ctrl;
		else if (hit_stat)
			rdata = val_stat;
		else if (hit_mask)
			rdata = val_mask;
		else
			rdata = 32'h00000000;
	end

	// one wait state: pready rises on the second access cycle
	// an unmapped address answers with pslverr and reads zero; its write is dropped
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end
		else
		begin
			pready <= access;
			pslverr <= access & ~mapped;
			prdata <= access ? rdata : prdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register writes
	wire logic link_on = link_ctrl[`LLDOC_F_LINK_EN];
	wire logic chan_down = link_ctrl[`LLDOC_F_PD];
	wire logic [3:0] test_sel = link_ctrl[`LLDOC_F_TEST_HI:`LLDOC_F_TEST_LO];

	// a locked write still lands and is only reported in status: refusing it
	// would silently lose the value, whereas landing it keeps software in charge
	// of the ordering rule that it owns
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			extra_lane_enable_link_b <= `LLDOC_RST_EXTRA_B;
			sync_word_content_select <= `LLDOC_RST_SYNC;
			filter_gain_double <= `LLDOC_RST_GAIN;
			threshold_i_level <= `LLDOC_RST_THR_I;
			threshold_q_level <= `LLDOC_RST_THR_Q;
			link_ctrl <= `LLDOC_RST_CTRL;
			irq_mask <= `LLDOC_RST_MASK;
		end
		else
		begin
			if (wr & hit_extra)
				extra_lane_enable_link_b <= wbyte;
			if (wr & hit_sync)
				sync_word_content_select <= wbyte[1:0];
			if (wr & hit_gain)
				filter_gain_double <= wbyte[`LLDOC_F_GAIN];
			if (wr & hit_thr_i)
				threshold_i_level <= wbyte;
			if (wr & hit_thr_q)
				threshold_q_level <= wbyte;
			if (wr & hit_ctrl)
				link_ctrl <= wbyte;
			if (wr & hit_mask)
				irq_mask <= wbyte[2:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// lane enables of the second link: the link mode or an extra-lane bit asks
	// for a lane, channel power-down vetoes both, the serializer flag adds power
	// to extra lanes, and a serializer clock needs every lower lane running;
	// lanes unused by the mode still follow its rate, only the ramp differs
	wire logic ser_extra = extra_lane_enable_link_b[`LLDOC_F_EXTRA_SER];
	wire logic test_off = (test_sel == `LLDOC_TEST_OFF) | (test_sel == `LLDOC_TEST_ALT);
	logic [LANES-1:0] lane_on;
	logic [LANES-1:0] extra_only;
	logic [LANES-1:0] ser_on;
	logic [LANES:0] lower_all_on;

	assign lower_all_on[0] = 1'b1;
	genvar n;
	generate
		for (n = 0; n < LANES; n++)
		begin : g_lane
			// lane 0 has no extra-lane bit, its bit position carries the serializer flag
			wire logic extra_req = (n != 0) && extra_lane_enable_link_b[n];
			assign extra_only[n] = extra_req & ~mode_lane_enable[n];
			// power-down wins over both sources
			assign lane_on[n] = (mode_lane_enable[n] | extra_req) & ~chan_down;
			// extra lanes get serializer power only with the flag set
			assign ser_on[n] = lane_on[n] & (mode_lane_enable[n] | ser_extra);
			// clock reaches serializer n only over an unbroken run of lower lanes
			assign lower_all_on[n+1] = lower_all_on[n] & lane_on[n];
		end
	endgenerate

	// lane outputs come from flops; rate and mode follow the link-mode decoder
	// a register write reaches the lanes one edge after the bus completes
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			lane_clock_enable <= '0;
			serializer_power <= '0;
			serializer_clock <= '0;
			lane_ramp_select <= '0;
			lane_test_pattern <= `LLDOC_TEST_OFF;
			link_enable <= 1'b0;
		end
		else
		begin
			lane_clock_enable <= lane_on;
			serializer_power <= ser_on;
			serializer_clock <= ser_on & lower_all_on[LANES-1:0];
			lane_ramp_select <= lane_on & extra_only & {LANES{test_off}};
			lane_test_pattern <= test_sel;
			link_enable <= link_on;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sync-word content, only meaningful under 64b/66b encoding
	wire logic sel_crc = sync_word_content_select == lldoc_pkg::LLDOC_SYNC_CRC;
	wire logic sel_fec = sync_word_content_select == lldoc_pkg::LLDOC_SYNC_FEC;

	// reserved codes are kept and read back as written, but send neither
	// signal rather than guessing one; command fields idle at zero, since
	// no command feature exists behind them and a receiver must see
	// idle headers only
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sync_send_crc <= 1'b0;
			sync_send_fec <= 1'b0;
			sync_command_fields <= 32'h00000000;
		end
		else
		begin
			sync_send_crc <= mode_is_64b66b & sel_crc;
			sync_send_fec <= mode_is_64b66b & sel_fec;
			sync_command_fields <= 32'h00000000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// gain stage: doubling saturates instead of wrapping when the sample clips;
	// a wrapped sample would flip sign and hide the over-range it caused, the
	// cost is one compare of the two top bits per sample
	function automatic lldoc_pkg::lldoc_sample_t gain(input lldoc_pkg::lldoc_sample_t s,
		input logic dbl);
		logic ovf;
		ovf = s[15] ^ s[14];
		if (!dbl)
			gain = s;
		else if (ovf)
			gain = s[15] ? 16'sh8000 : 16'sh7fff;
		else
			gain = {s[14:0], 1'b0};
	endfunction

	// magnitude of the top byte, nine bits so that -128 stays positive
	// the low byte is ignored on purpose: the threshold has only eight bits
	function automatic logic [8:0] mag(input lldoc_pkg::lldoc_sample_t s);
		logic [8:0] top;
		top = {s[15], s[15:8]};
		mag = s[15] ? 9'(~top + 9'h001) : top;
	endfunction

	// each path gets its own generated gain and compare stage, i at index 0 and q at index 1
	lldoc_pkg::lldoc_sample_t path_in [2];
	lldoc_pkg::lldoc_sample_t path_out [2];
	logic [7:0] path_thr [2];
	logic [1:0] path_hit;
	assign path_in[0] = sample_i;
	assign path_in[1] = sample_q;
	assign path_thr[0] = threshold_i_level;
	assign path_thr[1] = threshold_q_level;
	genvar p;
	generate
		for (p = 0; p < 2; p++)
		begin : g_path
			assign path_out[p] = gain(path_in[p], filter_gain_double);
			// threshold T against full scale 128, not the document's 256, is a plain compare on the top byte
			assign path_hit[p] = mag(path_out[p]) >= {1'b0, path_thr[p]};
		end
	endgenerate

	// named views of the two paths for the output stage and the events
	wire lldoc_pkg::lldoc_sample_t g_i = path_out[0];
	wire lldoc_pkg::lldoc_sample_t g_q = path_out[1];
	wire logic hit_i = path_hit[0];
	wire logic hit_q = path_hit[1];

	// one register stage keeps control bits aligned with their samples
	// held samples keep the last value, so a gap in the strobe reads as steady data
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			out_valid <= 1'b0;
			out_i <= 16'sh0000;
			out_q <= 16'sh0000;
			out_control <= 2'h0;
		end
		else
		begin
			out_valid <= sample_valid;
			out_i <= sample_valid ? g_i : out_i;
			out_q <= sample_valid ? g_q : out_q;
			out_control <= sample_valid ? {hit_q, hit_i} : out_control;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt events: over-range on i or q, and a locked write
	// the over-range events use the compare of the control bits, so a status
	// bit rises at the same edge as the control bit that caused it
	wire logic locked_wr = wr & link_on & (hit_extra | hit_sync);
	logic [2:0] ev;
	assign ev[`LLDOC_S_OVR_I] = sample_valid & hit_i;
	assign ev[`LLDOC_S_OVR_Q] = sample_valid & hit_q;
	assign ev[`LLDOC_S_LOCKED_WR] = locked_wr;

	// status after this edge: the read clears, then events are or-ed in, so an
	// event in the clearing cycle still sets; the mask after this edge is used
	// too, so irq follows a mask write at once instead of one cycle late
	wire logic [2:0] next_irq_status = (rd_stat ? 3'h0 : irq_status) | ev;
	wire logic [2:0] next_irq_mask = (wr & hit_mask) ? wbyte[2:0] : irq_mask;

	// status register and the registered interrupt level
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			irq_status <= 3'h0;
			irq <= 1'b0;
		end
		else
		begin
			irq_status <= next_irq_status;
			irq <= |(next_irq_status & next_irq_mask);
		end
	end

endmodule

// ### tb/lldoc_regs_asserts.sv
/*
 checker on the ports of the register group.
 assumes one clock clk and the active-high reset sys_rst.
*/
module lldoc_regs_asserts #(
	parameter int LANES = 8
)(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// bus and lanes
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic [LANES-1:0] mode_lane_enable,
	input wire logic mode_is_64b66b,
	input wire logic [LANES-1:0] lane_clock_enable,
	input wire logic [LANES-1:0] serializer_power,
	input wire logic [LANES-1:0] serializer_clock,
	input wire logic [LANES-1:0] lane_ramp_select,
	// sync word and samples
	input wire logic sync_send_crc,
	input wire logic sync_send_fec,
	input wire logic [31:0] sync_command_fields,
	input wire logic sample_valid,
	input wire logic out_valid
);
	logic [LANES-1:0] lower_on;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// all lanes below each index on, a gap anywhere starves the serializers above it
	always_comb
	begin
		lower_on[0] = 1'b1;
		for (int n = 1; n < LANES; n++)
			lower_on[n] = lower_on[n-1] & lane_clock_enable[n-1];
	end
	a_apb_wait: assert property (psel && penable && !pready |=> pready)
		else $error("apb answer late");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held too long");
	a_serclk_chain: assert property ((serializer_clock & ~lower_on) == '0)
		else $error("serializer clocked above a gap");
	a_clk_power: assert property ((serializer_clock & ~serializer_power) == '0)
		else $error("unpowered serializer clocked");
	a_power_lane: assert property ((serializer_power & ~lane_clock_enable) == '0)
		else $error("serializer powered on an idle lane");
	a_ramp_extra: assert property ((lane_ramp_select & $past(mode_lane_enable)) == '0)
		else $error("ramp on a mode lane");
	a_sync_excl: assert property (!(sync_send_crc && sync_send_fec))
		else $error("both sync contents selected");
	a_sync_mode: assert property (sync_send_crc || sync_send_fec |-> $past(mode_is_64b66b))
		else $error("sync content outside 64b66b");
	a_cmd_zero: assert property (sync_command_fields == '0)
		else $error("command field not idle");
	a_valid_next: assert property (out_valid == $past(sample_valid))
		else $error("output strobe misplaced");
	c_ramp: cover property (lane_ramp_select != '0);
	c_chain: cover property (serializer_clock[3]);
	c_fec: cover property (sync_send_fec);
endmodule

bind lldoc_regs lldoc_regs_asserts #(.LANES(LANES)) lldoc_regs_asserts_inst (.clk, .sys_rst,
	.psel, .penable, .pready, .mode_lane_enable, .mode_is_64b66b, .lane_clock_enable,
	.serializer_power, .serializer_clock, .lane_ramp_select, .sync_send_crc,
	.sync_send_fec, .sync_command_fields, .sample_valid, .out_valid);

// ### tb/lldoc_regs_test.sv
/*
 self-checking bench of the register group.
 assumes the apb map of the defines header; apb answers are awaited, not timed.
*/
`include "lldoc_defs.svh"
module lldoc_regs_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, er, irq;
	logic mode_is_64b66b, sample_valid, out_valid, link_enable, sync_send_crc, sync_send_fec;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, sync_command_fields;
	logic [7:0] mode_lane_enable, lane_clock_enable, serializer_power, serializer_clock;
	logic [7:0] lane_ramp_select;
	logic [3:0] lane_test_pattern;
	logic [1:0] out_control;
	lldoc_pkg::lldoc_sample_t sample_i, sample_q, out_i, out_q;
	int error_cnt = 0, cmp_count = 0, cyc = 0;
	// gain, i, q in; i, q, control bits out; both thresholds at 0x40
	logic [15:0] rows [5][6] = '{'{16'h0, 16'h3f00, 16'hc100, 16'h3f00, 16'hc100, 16'h0},
		'{16'h0, 16'h4000, 16'hc000, 16'h4000, 16'hc000, 16'h3},
		'{16'h0, 16'h8000, 16'h0000, 16'h8000, 16'h0000, 16'h1},
		'{16'h1, 16'h2000, 16'h1f00, 16'h4000, 16'h3e00, 16'h1},
		'{16'h1, 16'h7000, 16'h9000, 16'h7fff, 16'h8000, 16'h3}};
	logic [11:0] ra [8] = '{`LLDOC_ADDR_EXTRA_B, `LLDOC_ADDR_SYNC, `LLDOC_ADDR_GAIN,
		`LLDOC_ADDR_THR_I, `LLDOC_ADDR_THR_Q, `LLDOC_ADDR_CTRL, `LLDOC_ADDR_MASK,
		`LLDOC_ADDR_STAT};
	logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h00, 8'hf2, 8'hab, 8'h00, 8'h00, 8'h00};

	lldoc_regs lldoc_regs_inst (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .mode_lane_enable, .mode_is_64b66b, .lane_clock_enable,
		.serializer_power, .serializer_clock, .lane_ramp_select, .lane_test_pattern,
		.link_enable, .sync_send_crc, .sync_send_fec, .sync_command_fields, .sample_valid,
		.sample_i, .sample_q, .out_valid, .out_i, .out_q, .out_control, .irq);

	////////////////////////////////////////
	task automatic final_report();
		if (error_cnt == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one apb transfer, request held until pready is seen
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic smp(input logic [15:0] i, input logic [15:0] q);
		@(posedge clk);
		sample_valid <= 1'b1;
		sample_i <= i;
		sample_q <= q;
		@(posedge clk);
		sample_valid <= 1'b0;
		@(negedge clk);
	endtask
	// control and extra-lane write, then clock, power, serializer clock and ramp
	task automatic ln(input logic [7:0] c, input logic [7:0] e, input logic [31:0] x);
		apb(1'b1, `LLDOC_ADDR_CTRL, {24'h0, c});
		apb(1'b1, `LLDOC_ADDR_EXTRA_B, {24'h0, e});
		repeat (2) @(negedge clk);
		chk({lane_clock_enable, serializer_power, serializer_clock, lane_ramp_select}, x);
	endtask

	////////////////////////////////////////
	// clock and a ceiling on the run
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			error_cnt++;
			final_report();
		end
	end
	initial
	begin
		{sys_rst, psel, penable, pwrite, mode_is_64b66b, sample_valid} = 6'h20;
		{paddr, pwdata, mode_lane_enable, sample_i, sample_q} = '0;
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		apb(1'b1, `LLDOC_ADDR_THR_I, 32'h40);
		apb(1'b1, `LLDOC_ADDR_THR_Q, 32'h40);
		apb(1'b0, `LLDOC_ADDR_THR_I, 32'h0);
		chk(rd, 32'h40);
		for (int r = 0; r < 5; r++)
		begin
			apb(1'b1, `LLDOC_ADDR_GAIN, {16'h0, rows[r][0]});
			smp(rows[r][1], rows[r][2]);
			chk({out_i, out_q}, {rows[r][3], rows[r][4]});
			chk({28'h0, out_valid, irq, out_control}, {29'h1, 1'b0, rows[r][5][1:0]});
		end
		// masked events stay sticky, read clears them
		apb(1'b0, `LLDOC_ADDR_STAT, 32'h0);
		chk(rd, 32'h3);
		apb(1'b1, `LLDOC_ADDR_MASK, 32'h1);
		smp(16'h0, 16'hc000);
		chk({31'h0, irq}, 32'h0);
		smp(16'h4000, 16'h0);
		chk({31'h0, irq}, 32'h1);
		apb(1'b0, `LLDOC_ADDR_STAT, 32'h0);
		chk(rd, 32'h3);
		repeat (2) @(negedge clk);
		chk({31'h0, irq}, 32'h0);
		apb(1'b0, 12'h000, 32'h0);
		chk({er, rd[30:0]}, 32'h80000000);
		// every sync code in 64b66b, then crc code outside it
		mode_is_64b66b <= 1'b1;
		for (int c = 0; c < 4; c++)
		begin
			apb(1'b1, `LLDOC_ADDR_SYNC, c);
			repeat (2) @(negedge clk);
			chk({30'h0, sync_send_fec, sync_send_crc}, (c == 0) ? 1 : (c == 2) ? 2 : 0);
			chk(sync_command_fields, 32'h0);
		end
		@(posedge clk);
		mode_is_64b66b <= 1'b0;
		apb(1'b1, `LLDOC_ADDR_SYNC, 32'h0);
		repeat (2) @(negedge clk);
		chk({30'h0, sync_send_fec, sync_send_crc}, 32'h0);
		@(posedge clk);
		mode_lane_enable <= 8'h03;
		ln(8'h00, 8'h0a, {8'h0b, 8'h03, 8'h03, 8'h08});
		ln(8'h00, 8'h0b, {8'h0b, 8'h0b, 8'h03, 8'h08});
		ln(8'h00, 8'h0f, {8'h0f, 8'h0f, 8'h0f, 8'h0c});
		ln(8'h40, 8'h0f, {8'h0f, 8'h0f, 8'h0f, 8'h00});
		chk({28'h0, lane_test_pattern}, 32'h4);
		ln(8'h50, 8'h0f, {8'h0f, 8'h0f, 8'h0f, 8'h0c});
		ln(8'h02, 8'h0f, 32'h0);
		// a write while the link runs is flagged
		apb(1'b1, `LLDOC_ADDR_CTRL, 32'h1);
		apb(1'b1, `LLDOC_ADDR_SYNC, 32'h2);
		apb(1'b0, `LLDOC_ADDR_STAT, 32'h0);
		chk({rd[31:3], rd[2]}, 30'h1);
		chk({31'h0, link_enable}, 32'h1);
		// second reset in mid-run restores defaults
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		for (int r = 0; r < 8; r++)
		begin
			apb(1'b0, ra[r], 32'h0);
			chk(rd, {24'h0, rv[r]});
		end
		chk({30'h0, link_enable, irq}, 32'h0);
		final_report();
	end
endmodule
